// file: logic/sarc_pkg.sv
// Shared constants and types of the converter control block.
package sarc_pkg;

  // Register addresses on the special function register bus.
  localparam logic [7:0] ADDR_CONVERTER_CONFIG = 8'hbc;
  localparam logic [7:0] ADDR_RESULT_LOW_BYTE = 8'hbe;
  localparam logic [7:0] ADDR_RESULT_HIGH_BYTE = 8'hbf;
  localparam logic [7:0] ADDR_CONVERTER_CONTROL = 8'he8;

  // Reset values of the four registers.
  localparam logic [7:0] RST_CONVERTER_CONFIG = 8'h60;
  localparam logic [7:0] RST_CONVERTER_CONTROL = 8'h00;
  localparam logic [7:0] RST_RESULT_BYTE = 8'h00;

  // Bit positions in the control register.
  localparam int CTL_CONVERTER_ON = 7;
  localparam int CTL_TRACK_MODE = 6;
  localparam int CTL_DONE_FLAG = 5;
  localparam int CTL_BUSY = 4;
  localparam int CTL_SRC_HI = 3;
  localparam int CTL_SRC_LO = 2;
  localparam int CTL_WINDOW_FLAG = 1;
  localparam int CTL_LEFT_ALIGN = 0;

  // Field positions in the configuration register.
  localparam int CFG_DIV_HI = 7;
  localparam int CFG_DIV_LO = 5;
  localparam int CFG_GAIN_HI = 2;
  localparam int CFG_GAIN_LO = 0;

  // Unused configuration bits 4-3 read as zero.
  localparam logic [1:0] CFG_UNUSED_READ = 2'h0;

  // A zero nibble used when packing the result bytes.
  localparam logic [3:0] NIBBLE_ZERO = 4'h0;

  // Answer on an unmapped or idle read.
  localparam logic [7:0] READ_IDLE = 8'h00;

  // Converter clocks spent tracking in the timed low power track modes.
  localparam logic [4:0] TRACK_SAR_CLKS = 5'h03;

  // Divider helpers: unit value and the shift used for codes 1xx.
  localparam logic [4:0] DIV_ONE = 5'h01;
  localparam logic [2:0] DIV_SHIFT_MAX = 3'h4;

  // Start-of-conversion sources.
  typedef enum logic [1:0] {
    SRC_SOFTWARE = 2'h0,
    SRC_TIMER3 = 2'h1,
    SRC_EXT_STROBE = 2'h2,
    SRC_TIMER2 = 2'h3
  } sarc_src_type;

  // Sequencer states, one-hot.
  typedef enum logic [2:0] {
    ST_IDLE = 3'h1,
    ST_TRACK = 3'h2,
    ST_CONV = 3'h4
  } sarc_state_type;

endpackage : sarc_pkg

// file: logic/sarc_clkdiv.sv
// Converter clock divider producing one tick every 1, 2, 4, 8 or 16 clocks.
`timescale 1ns/10ps
module sarc_clkdiv
  import sarc_pkg::*;
#(
  parameter int CNT_W = 4
)
(
  input wire logic i_clk, // System clock.
  input wire logic i_rst_n, // Synchronised reset, active low.
  input wire logic i_clk_en, // Freezes the divider while low.
  input wire logic i_run, // Divider counts while high.
  input wire logic [2:0] i_div_code, // Clock divide field.
  output logic o_tick // One-cycle pulse per converter clock.
);

  logic [CNT_W-1:0] cnt; // Position inside the current period.
  logic [2:0] shift; // Log2 of the divide ratio.
  logic [CNT_W-1:0] term; // Last count of a period.

  // Codes 1xx all select the largest ratio.
  always_comb
  begin
    shift = i_div_code[2] ? DIV_SHIFT_MAX : {1'b0, i_div_code[1:0]};
    term = CNT_W'((DIV_ONE << shift) - DIV_ONE);
  end

  // The count restarts whenever the divider is stopped, so the first tick
  // after a start always follows a full period.
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      cnt <= '0;
      o_tick <= 1'b0;
    end
    else if (i_clk_en)
    begin
      if (!i_run)
      begin
        cnt <= '0;
        o_tick <= 1'b0;
      end
      else if (cnt >= term)
      begin
        cnt <= '0;
        o_tick <= 1'b1;
      end
      else
      begin
        cnt <= CNT_W'(cnt + 1'b1);
        o_tick <= 1'b0;
      end
    end
  end

endmodule : sarc_clkdiv

// file: logic/sarc_top.sv
// Control, sequencing and result formatting of the successive-approximation converter.
`timescale 1ns/10ps
// Notes on behaviour
// - Converter clock divides system clock by 1-16.
// - Converter off means low power shutdown.
// - Track mode 0 tracks except while converting.
// - Timed track modes track three converter clocks.
// - Strobe track mode tracks while strobe low.
// - Done flag set by hardware, cleared by software.
// - Busy reads one only during timed tracking and conversion.
// - Interrupt request on the busy fall that ends a completed conversion, not on an abort.
// - Done flag set on the busy fall that ends a completed conversion, not on an abort.
// - Busy write one starts only with source 00.
// - Timer overflows start conversions in modes 01/11.
// - Strobe rising edge starts conversion in mode 10.
// - Window flag sticks until software clears it.
// - Left-align bit selects result placement.
// - Right-justified bytes with sign or zero extension.
// - Left-justified bytes, low nibble reads zero.
// - Differential results are two's complement.
module sarc_top
  import sarc_pkg::*;
#(
  parameter int CONV_SAR_CLKS = 16, // Converter clocks spent in a conversion.
  parameter int RESULT_BITS = 12 // Width of the converter code.
)
(
  input wire logic i_clk, // System clock, 10 MHz.
  input wire logic i_rst_n, // Asynchronous reset, active low.
  input wire logic i_clk_en, // Freezes all state except the reset synchroniser while low.
  input wire logic [7:0] i_sfr_addr, // Register address.
  input wire logic i_sfr_wr, // Write strobe, one cycle.
  input wire logic i_sfr_rd, // Read strobe, one cycle.
  input wire logic [7:0] i_sfr_wdata, // Write data.
  output logic [7:0] o_sfr_rdata, // Read data, one cycle after the strobe.
  input wire logic i_timer3_ovf, // Timer 3 overflow pulse.
  input wire logic i_timer2_ovf, // Timer 2 overflow pulse.
  input wire logic i_ext_convert_strobe, // External convert strobe pin.
  input wire logic [RESULT_BITS-1:0] i_sar_code, // Raw code from the analog array.
  input wire logic i_differential, // Selected input is a differential pair.
  input wire logic i_window_match, // Window comparator match pulse.
  input wire logic i_conv_irq_en, // Converter interrupt enable.
  output logic o_shutdown, // Analog converter in low power shutdown.
  output logic o_track, // Track-and-hold is tracking.
  output logic o_convert, // Analog array is converting.
  output logic o_sar_tick, // Converter clock tick.
  output logic [2:0] o_amp_gain_select, // Amplifier gain to the analog side.
  output logic o_convert_busy, // Busy state.
  output logic o_conversion_done_flag, // Sticky completion flag.
  output logic o_conv_irq // Interrupt request pulse.
);

  localparam int CNT_W = $clog2(CONV_SAR_CLKS + 1); // Phase counter width.
  localparam logic [CNT_W-1:0] CONV_LAST = CNT_W'(CONV_SAR_CLKS - 1); // Last conversion tick.
  localparam logic [CNT_W-1:0] TRACK_LAST = CNT_W'(TRACK_SAR_CLKS - 5'h01); // Last track tick.

  logic rst_meta_n; // First reset synchroniser stage.
  logic rst_n; // Synchronised reset used by all logic.
  logic strobe_meta; // First strobe synchroniser stage.
  logic strobe_sync; // Synchronised strobe level.
  logic strobe_prev; // Strobe level one cycle earlier.
  logic strobe_rise; // Rising edge of the strobe.
  logic converter_on; // Converter enable bit.
  logic track_mode_select; // Low power track mode bit.
  sarc_src_type start_source_select; // Start source field.
  logic left_align; // Result placement bit.
  logic window_match_flag; // Sticky window flag.
  logic [2:0] sar_clock_divide; // Clock divide field.
  logic [2:0] amp_gain_select; // Amplifier gain field.
  logic [7:0] result_low_byte; // Low data byte.
  logic [7:0] result_high_byte; // High data byte.
  sarc_state_type state; // Sequencer state.
  sarc_state_type next_state; // Next sequencer state.
  logic [CNT_W-1:0] phase_cnt; // Converter clocks in the current phase.
  logic sar_tick; // Divider tick.
  logic wr_ctl; // Write to the control register.
  logic sw_start; // Software start request.
  logic start_evt; // Start event of the selected source.
  logic hw_start; // Start event of a hardware source.
  logic start_on; // Enable bit in force for the start being decided.
  logic start_track; // The start being decided tracks first.
  logic capture; // Conversion completes this cycle.
  logic done_pending; // Busy fell after a completed conversion.
  logic next_track; // Next track output.
  logic [RESULT_BITS-1:0] sar_word; // Result word in its final encoding.
  logic [7:0] next_low; // Formatted low byte.
  logic [7:0] next_high; // Formatted high byte.
  logic [7:0] next_rdata; // Read multiplexer.

  // Reset release passes two flip-flops so that no flop leaves reset in a
  // different cycle than its neighbours.
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      rst_meta_n <= 1'b0;
      rst_n <= 1'b0;
    end
    else
    begin
      rst_meta_n <= 1'b1;
      rst_n <= rst_meta_n;
    end
  end

  // The strobe pin is asynchronous; only the second stage feeds logic.
  always_ff @(posedge i_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      strobe_meta <= 1'b0;
      strobe_sync <= 1'b0;
      strobe_prev <= 1'b0;
    end
    else if (i_clk_en)
    begin
      strobe_meta <= i_ext_convert_strobe;
      strobe_sync <= strobe_meta;
      strobe_prev <= strobe_sync;
    end
  end

  assign strobe_rise = strobe_sync & ~strobe_prev;
  assign wr_ctl = i_sfr_wr && (i_sfr_addr == ADDR_CONVERTER_CONTROL);

  // software start decode.
  // The source field of the same write decides, so one byte write can select
  // the software source and start at once; a written zero does nothing.
  assign sw_start = wr_ctl && i_sfr_wdata[CTL_BUSY]
                    && (i_sfr_wdata[CTL_SRC_HI:CTL_SRC_LO] == SRC_SOFTWARE);

  always_comb
  begin
    case (start_source_select)
      SRC_TIMER3: hw_start = i_timer3_ovf;
      SRC_EXT_STROBE: hw_start = strobe_rise;
      SRC_TIMER2: hw_start = i_timer2_ovf;
      default: hw_start = 1'b0;
    endcase
  end

  assign start_evt = sw_start || hw_start;

  // A software start takes the enable and track mode from its own write, so
  // one byte can switch the converter on and start it.
  always_comb
  begin
    if (sw_start)
    begin
      start_on = i_sfr_wdata[CTL_CONVERTER_ON];
      start_track = i_sfr_wdata[CTL_TRACK_MODE];
    end
    else
    begin
      start_on = converter_on;
      start_track = track_mode_select && (start_source_select != SRC_EXT_STROBE);
    end
  end

  // converter clock divider.
  // The divider runs only while the sequencer tracks or converts, which both saves
  // power and aligns the first converter clock with the start event.
  sarc_clkdiv #(
    .CNT_W(4)
  ) u_clkdiv (
    .i_clk(i_clk),
    .i_rst_n(rst_n),
    .i_clk_en(i_clk_en),
    .i_run(converter_on && (state != ST_IDLE)),
    .i_div_code(sar_clock_divide),
    .o_tick(sar_tick)
  );

  // Sequencer. Starts are ignored while busy; switching the converter off
  // aborts a conversion without a result.
  always_comb
  begin
    next_state = state;
    case (state)
      ST_IDLE:
      begin
        if (start_on && start_evt)
        begin
          if (start_track)
            next_state = ST_TRACK;
          else
            next_state = ST_CONV;
        end
      end
      ST_TRACK:
      begin
        if (!converter_on)
          next_state = ST_IDLE;
        else if (sar_tick && (phase_cnt == TRACK_LAST))
          next_state = ST_CONV;
      end
      ST_CONV:
      begin
        if (!converter_on)
          next_state = ST_IDLE;
        else if (sar_tick && (phase_cnt == CONV_LAST))
          next_state = ST_IDLE;
      end
      default: next_state = ST_IDLE;
    endcase
  end

  assign capture = (state == ST_CONV) && (next_state == ST_IDLE) && converter_on;

  // State, busy and phase counter.
  always_ff @(posedge i_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state <= ST_IDLE;
      o_convert_busy <= 1'b0;
      phase_cnt <= '0;
    end
    else if (i_clk_en)
    begin
      state <= next_state;
      o_convert_busy <= (next_state != ST_IDLE);
      if (next_state != state)
        phase_cnt <= '0;
      else if (sar_tick)
        phase_cnt <= CNT_W'(phase_cnt + 1'b1);
    end
  end

  // Analog control lines.
  always_comb
  begin
    next_track = 1'b0;
    if (!converter_on)
      next_track = 1'b0;
    else if (!track_mode_select)
      next_track = (next_state != ST_CONV);
    else if (start_source_select == SRC_EXT_STROBE)
      next_track = !strobe_sync && (next_state != ST_CONV);
    else
      next_track = (next_state == ST_TRACK);
  end

  always_ff @(posedge i_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      o_shutdown <= 1'b1;
      o_track <= 1'b0;
      o_convert <= 1'b0;
    end
    else if (i_clk_en)
    begin
      o_shutdown <= !converter_on;
      o_track <= next_track;
      o_convert <= (next_state == ST_CONV);
    end
  end

  assign o_sar_tick = sar_tick;
  assign o_amp_gain_select = amp_gain_select;

  // differential code to two's complement.
  // The analog array delivers offset binary; flipping the top bit turns it
  // into two's complement without an adder.
  assign sar_word = i_differential ? {~i_sar_code[RESULT_BITS-1], i_sar_code[RESULT_BITS-2:0]}
                                   : i_sar_code;

  always_comb
  begin
    if (left_align)
    begin
      next_high = sar_word[11:4];
      next_low = {sar_word[3:0], NIBBLE_ZERO};
    end
    else
    begin
      next_low = sar_word[7:0];
      next_high = {i_differential ? {4{sar_word[11]}} : NIBBLE_ZERO, sar_word[11:8]};
    end
  end

  // Data bytes. A capture outranks a software write in the same cycle.
  always_ff @(posedge i_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      result_low_byte <= RST_RESULT_BYTE;
      result_high_byte <= RST_RESULT_BYTE;
    end
    else if (i_clk_en)
    begin
      if (capture)
      begin
        result_low_byte <= next_low;
        result_high_byte <= next_high;
      end
      else if (i_sfr_wr && (i_sfr_addr == ADDR_RESULT_LOW_BYTE))
        result_low_byte <= i_sfr_wdata;
      else if (i_sfr_wr && (i_sfr_addr == ADDR_RESULT_HIGH_BYTE))
        result_high_byte <= i_sfr_wdata;
    end
  end

  // Configuration and control fields written by software.
  always_ff @(posedge i_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sar_clock_divide <= RST_CONVERTER_CONFIG[CFG_DIV_HI:CFG_DIV_LO];
      amp_gain_select <= RST_CONVERTER_CONFIG[CFG_GAIN_HI:CFG_GAIN_LO];
      converter_on <= RST_CONVERTER_CONTROL[CTL_CONVERTER_ON];
      track_mode_select <= RST_CONVERTER_CONTROL[CTL_TRACK_MODE];
      start_source_select <= sarc_src_type'(RST_CONVERTER_CONTROL[CTL_SRC_HI:CTL_SRC_LO]);
      left_align <= RST_CONVERTER_CONTROL[CTL_LEFT_ALIGN];
    end
    else if (i_clk_en)
    begin
      if (i_sfr_wr && (i_sfr_addr == ADDR_CONVERTER_CONFIG))
      begin
        sar_clock_divide <= i_sfr_wdata[CFG_DIV_HI:CFG_DIV_LO];
        amp_gain_select <= i_sfr_wdata[CFG_GAIN_HI:CFG_GAIN_LO];
      end
      if (wr_ctl)
      begin
        converter_on <= i_sfr_wdata[CTL_CONVERTER_ON];
        track_mode_select <= i_sfr_wdata[CTL_TRACK_MODE];
        start_source_select <= sarc_src_type'(i_sfr_wdata[CTL_SRC_HI:CTL_SRC_LO]);
        left_align <= i_sfr_wdata[CTL_LEFT_ALIGN];
      end
    end
  end

  // Sticky flags and the interrupt pulse. Hardware setting wins over a
  // software clear in the same cycle so that no event is lost.
  always_ff @(posedge i_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      done_pending <= 1'b0;
      o_conversion_done_flag <= RST_CONVERTER_CONTROL[CTL_DONE_FLAG];
      window_match_flag <= RST_CONVERTER_CONTROL[CTL_WINDOW_FLAG];
      o_conv_irq <= 1'b0;
    end
    else if (i_clk_en)
    begin
      done_pending <= capture;
      if (done_pending)
        o_conversion_done_flag <= 1'b1;
      else if (wr_ctl)
        o_conversion_done_flag <= i_sfr_wdata[CTL_DONE_FLAG];
      if (i_window_match)
        window_match_flag <= 1'b1;
      else if (wr_ctl)
        window_match_flag <= i_sfr_wdata[CTL_WINDOW_FLAG];
      o_conv_irq <= done_pending && i_conv_irq_en;
    end
  end

  // Register read, answered one cycle after the strobe.
  always_comb
  begin
    if (!i_sfr_rd)
      next_rdata = READ_IDLE;
    else if (i_sfr_addr == ADDR_CONVERTER_CONFIG)
      next_rdata = {sar_clock_divide, CFG_UNUSED_READ, amp_gain_select};
    else if (i_sfr_addr == ADDR_CONVERTER_CONTROL)
      next_rdata = {converter_on, track_mode_select, o_conversion_done_flag, o_convert_busy,
                    start_source_select, window_match_flag, left_align};
    else if (i_sfr_addr == ADDR_RESULT_LOW_BYTE)
      next_rdata = result_low_byte;
    else if (i_sfr_addr == ADDR_RESULT_HIGH_BYTE)
      next_rdata = result_high_byte;
    else
      next_rdata = READ_IDLE;
  end

  always_ff @(posedge i_clk or negedge rst_n)
  begin
    if (!rst_n)
      o_sfr_rdata <= READ_IDLE;
    else if (i_clk_en)
      o_sfr_rdata <= next_rdata;
  end

  // Checks on the sequencer, flags and formatting.
  chk_shutdown_idle: assert property (@(posedge i_clk) disable iff (!rst_n)
    (i_clk_en && !converter_on && !(sw_start && i_sfr_wdata[CTL_CONVERTER_ON]))
    |=> (state == ST_IDLE && o_shutdown))
    else $error("converter off but sequencer active");

  chk_hold_in_conv: assert property (@(posedge i_clk) disable iff (!rst_n)
    (i_clk_en && next_state == ST_CONV) |=> (o_convert && !o_track))
    else $error("tracking while converting");

  chk_track_length: assert property (@(posedge i_clk) disable iff (!rst_n)
    (i_clk_en && state == ST_TRACK && converter_on && sar_tick && phase_cnt == TRACK_LAST)
    |=> (state == ST_CONV))
    else $error("track phase did not end after three converter clocks");

  chk_strobe_track: assert property (@(posedge i_clk) disable iff (!rst_n)
    (i_clk_en && converter_on && track_mode_select
     && start_source_select == SRC_EXT_STROBE && strobe_sync) |=> !o_track)
    else $error("tracking while strobe high");

  chk_done_after: assert property (@(posedge i_clk) disable iff (!rst_n)
    (i_clk_en && capture) |=> (!o_convert_busy && done_pending))
    else $error("busy did not fall at conversion end");

  chk_done_set: assert property (@(posedge i_clk) disable iff (!rst_n)
    (i_clk_en && done_pending) |=> o_conversion_done_flag)
    else $error("done flag not set after busy fall");

  chk_sw_start: assert property (@(posedge i_clk) disable iff (!rst_n)
    (i_clk_en && sw_start && i_sfr_wdata[CTL_CONVERTER_ON] && state == ST_IDLE)
    |=> o_convert_busy)
    else $error("software start ignored");

  chk_no_start: assert property (@(posedge i_clk) disable iff (!rst_n)
    (i_clk_en && state == ST_IDLE && !start_evt) |=> (state == ST_IDLE))
    else $error("conversion began without a start event");

  chk_irq_pulse: assert property (@(posedge i_clk) disable iff (!rst_n)
    (i_clk_en && done_pending && i_conv_irq_en) |=> o_conv_irq)
    else $error("missing interrupt request at busy fall");

  chk_window_hold: assert property (@(posedge i_clk) disable iff (!rst_n)
    (window_match_flag && !(wr_ctl && i_clk_en)) |=> window_match_flag)
    else $error("window flag lost without software clear");

  chk_left_nibble: assert property (@(posedge i_clk) disable iff (!rst_n)
    (i_clk_en && capture && left_align) |=> (result_low_byte[3:0] == NIBBLE_ZERO))
    else $error("left-justified low nibble not zero");

  cov_sw_conv: cover property (@(posedge i_clk) disable iff (!rst_n)
    sw_start ##[1:400] done_pending);
  cov_strobe_conv: cover property (@(posedge i_clk) disable iff (!rst_n)
    (start_source_select == SRC_EXT_STROBE && strobe_rise) ##[1:400] done_pending);
  cov_timed_track: cover property (@(posedge i_clk) disable iff (!rst_n)
    (state == ST_TRACK) ##[1:100] (state == ST_CONV));

endmodule : sarc_top

// file: verif/sarc_analog_model.sv
// Analog array and window comparator model facing the converter control block.
`timescale 1ns/10ps
module sarc_analog_model
  import sarc_pkg::*;
(
  input wire logic i_clk, // System clock.
  input wire logic i_convert, // Conversion phase from the block.
  input wire logic [11:0] i_level, // Code the input voltage would give.
  input wire logic i_win_hit, // The level lies inside the window.
  output logic [11:0] o_code, // Raw code to the block.
  output logic o_window_match // One-cycle match pulse.
);
  logic convert_d; // Conversion phase one cycle ago.
  // Outside a conversion the code is not valid, so it shows the inverse level.
  assign o_code = i_convert ? i_level : ~i_level;
  // Remember the phase so that the end of a conversion can be seen.
  always_ff @(posedge i_clk)
  begin
    convert_d <= i_convert;
  end
  // The comparator reports once, just after a conversion ends.
  assign o_window_match = convert_d & ~i_convert & i_win_hit;
endmodule : sarc_analog_model

// file: verif/tb_sarc_top.sv
// Self-checking bench of the converter control block.
`timescale 1ns/10ps
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin mismatches++; \
  $display("ERROR %0t: got %h expected %h", $time, g, e); end end
module tb_sarc_top
  import sarc_pkg::*;
;
  localparam int CONV = 4; // Short conversion keeps the run brief.
  logic clk, rst_n, wr, rd, t3, t2, stb, diff, irq_en, win_hit; // Bench drives.
  logic [7:0] addr, wdata, rdata; // Register bus.
  logic [11:0] level, code; // Analog level and array code.
  logic win, shut, trk, cnv, tick, busy, done, irq; // Block outputs.
  logic [2:0] gain; // Amplifier gain output.
  int mismatches, comparisons, c, n0, n1; // Bookkeeping.
  sarc_top #(.CONV_SAR_CLKS(CONV), .RESULT_BITS(12)) dut_u (.i_clk(clk), .i_rst_n(rst_n),
    .i_clk_en(1'b1), .i_sfr_addr(addr), .i_sfr_wr(wr), .i_sfr_rd(rd), .i_sfr_wdata(wdata),
    .o_sfr_rdata(rdata), .i_timer3_ovf(t3), .i_timer2_ovf(t2), .i_ext_convert_strobe(stb),
    .i_sar_code(code), .i_differential(diff), .i_window_match(win), .i_conv_irq_en(irq_en),
    .o_shutdown(shut), .o_track(trk), .o_convert(cnv), .o_sar_tick(tick),
    .o_amp_gain_select(gain), .o_convert_busy(busy), .o_conversion_done_flag(done),
    .o_conv_irq(irq));
  sarc_analog_model model_u (.i_clk(clk), .i_convert(cnv), .i_level(level),
    .i_win_hit(win_hit), .o_code(code), .o_window_match(win));
  // Free-running 10 MHz clock.
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // One write cycle: strobe held through exactly one taking edge.
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    #1;
    addr = a;
    wdata = d;
    wr = 1'b1;
    @(posedge clk);
    #1;
    wr = 1'b0;
  endtask : wr_reg
  // One read cycle; the answer stands only in the cycle after the taking edge.
  task automatic rd_reg(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    #1;
    addr = a;
    rd = 1'b1;
    @(posedge clk);
    #1;
    rd = 1'b0;
    `CHK(rdata, e)
  endtask : rd_reg
  // A timer overflow pulse on one timer line, one cycle long.
  task automatic pulse(input int which);
    @(posedge clk);
    #1;
    if (which == 3) t3 = 1'b1;
    else t2 = 1'b1;
    @(posedge clk);
    #1;
    t3 = 1'b0;
    t2 = 1'b0;
  endtask : pulse
  // Counts busy cycles of one conversion, then checks the flag order.
  task automatic wait_done(output int n);
    n = 0;
    for (int k = 0; k < 2000; k++)
    begin
      if (busy === 1'b1) n++;
      else if (n > 0) break;
      @(posedge clk);
      #1;
    end
    `CHK(n > 0, 1'b1)
    `CHK(done, 1'b0)
    @(posedge clk);
    #1;
    `CHK(done, 1'b1)
    `CHK(irq, irq_en)
  endtask : wait_done
  // One software conversion followed by a read of both data bytes.
  task automatic fmt(input logic [7:0] ctl, input logic d, input logic [11:0] lv,
    input logic [7:0] hi, input logic [7:0] lo);
    int n;
    diff = d;
    level = lv;
    wr_reg(ADDR_CONVERTER_CONTROL, ctl);
    wait_done(n);
    rd_reg(ADDR_RESULT_HIGH_BYTE, hi);
    rd_reg(ADDR_RESULT_LOW_BYTE, lo);
  endtask : fmt
  // Prints the verdict and stops the run.
  task automatic end_of_test();
    if (mismatches == 0 && comparisons > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : end_of_test
  // Watchdog: the sequence needs a few thousand cycles at most.
  initial
  begin
    #(100 * 20000);
    mismatches++;
    end_of_test();
  end
  initial
  begin
    {rst_n, wr, rd, t3, t2, stb, diff, irq_en, win_hit} = '0;
    {addr, wdata, level, mismatches, comparisons} = '0;
    repeat (12) @(posedge clk);
    #1 rst_n = 1'b1;
    repeat (3) @(posedge clk);
    `CHK(shut, 1'b1)
    rd_reg(ADDR_CONVERTER_CONFIG, RST_CONVERTER_CONFIG);
    rd_reg(ADDR_RESULT_LOW_BYTE, 8'h00);
    rd_reg(ADDR_RESULT_HIGH_BYTE, 8'h00);
    rd_reg(ADDR_CONVERTER_CONTROL, 8'h00);
    rd_reg(8'h00, READ_IDLE);
    wr_reg(ADDR_CONVERTER_CONFIG, 8'h1d);
    rd_reg(ADDR_CONVERTER_CONFIG, 8'h05);
    `CHK(gain, 3'h5)
    // Timed tracking adds three converter clocks for divide codes 0 to 4.
    for (c = 0; c < 5; c++)
    begin
      wr_reg(ADDR_CONVERTER_CONFIG, {c[2:0], 5'h00});
      wr_reg(ADDR_CONVERTER_CONTROL, 8'h90);
      wait_done(n0);
      `CHK(trk, 1'b1)
      if (c == 0) `CHK(n0, CONV + 1)
      wr_reg(ADDR_CONVERTER_CONTROL, 8'hd0);
      wait_done(n1);
      `CHK(n1 - n0, 3 << c)
    end
    irq_en = 1'b1;
    fmt(8'h90, 1'b0, 12'habc, 8'h0a, 8'hbc);
    fmt(8'h91, 1'b0, 12'habc, 8'hab, 8'hc0);
    fmt(8'h90, 1'b1, 12'h123, 8'hf9, 8'h23);
    fmt(8'h90, 1'b1, 12'h9a5, 8'h01, 8'ha5);
    fmt(8'h91, 1'b1, 12'h123, 8'h92, 8'h30);
    // A sticky window flag, then a software clear of both flags.
    win_hit = 1'b1;
    fmt(8'h90, 1'b0, 12'h100, 8'h01, 8'h00);
    win_hit = 1'b0;
    repeat (5) @(posedge clk);
    rd_reg(ADDR_CONVERTER_CONTROL, 8'ha2);
    wr_reg(ADDR_CONVERTER_CONTROL, 8'h80);
    rd_reg(ADDR_CONVERTER_CONTROL, 8'h80);
    // Busy written with a timer source stays idle; only that timer starts.
    wr_reg(ADDR_CONVERTER_CONTROL, 8'h94);
    pulse(2);
    repeat (3) @(posedge clk);
    `CHK(busy, 1'b0)
    pulse(3);
    wait_done(n0);
    wr_reg(ADDR_CONVERTER_CONTROL, 8'h8c);
    pulse(2);
    wait_done(n0);
    // Strobe source with strobe-driven tracking.
    wr_reg(ADDR_CONVERTER_CONTROL, 8'hc8);
    repeat (4) @(posedge clk);
    `CHK(trk, 1'b1)
    #1;
    stb = 1'b1;
    wait_done(n0);
    `CHK(trk, 1'b0)
    stb = 1'b0;
    // Switching off mid-conversion aborts without a completion.
    wr_reg(ADDR_CONVERTER_CONTROL, 8'h90);
    `CHK(busy, 1'b1)
    repeat (2) @(posedge clk);
    wr_reg(ADDR_CONVERTER_CONTROL, 8'h00);
    // Wait past the full conversion time to show that no completion follows.
    repeat (80) @(posedge clk);
    #1;
    `CHK({busy, done, shut, tick, cnv}, 5'h04)
    end_of_test();
  end
endmodule : tb_sarc_top
